// ==== shared/pfm_pkg.sv ====
// Constants for the port function select multiplexer
package pfm_pkg;
   // Register byte addresses
   localparam logic [15:0] PFM_ADDR_PORT0_SEL = 16'h4420;
   localparam logic [15:0] PFM_ADDR_PORT1_LOW_SEL = 16'h4422;
   localparam logic [15:0] PFM_ADDR_PORT1_HIGH_SEL = 16'h4423;
   localparam logic [15:0] PFM_ADDR_PORT2_HIGH_SEL = 16'h4425;
   localparam logic [15:0] PFM_ADDR_PORT3_LOW_SEL = 16'h4426;
   // Reset value shared by every select register
   localparam logic [7:0] PFM_SEL_RESET = 8'h00;
   // Writable bits; reserved bits are held at zero
   localparam logic [7:0] PFM_MASK_PORT0 = 8'hFF;
   localparam logic [7:0] PFM_MASK_PORT1_LOW = 8'hFF;
   localparam logic [7:0] PFM_MASK_PORT1_HIGH = 8'h3F;
   localparam logic [7:0] PFM_MASK_PORT2_HIGH = 8'hFC;
   localparam logic [7:0] PFM_MASK_PORT3_LOW = 8'h3F;
   // Field positions inside a select register
   localparam int PFM_FLD0_LSB = 0;
   localparam int PFM_FLD1_LSB = 2;
   localparam int PFM_FLD2_LSB = 4;
   localparam int PFM_FLD3_LSB = 6;
   // Function codes
   localparam logic [1:0] PFM_FN0 = 2'h0;
   localparam logic [1:0] PFM_FN1 = 2'h1;
   localparam logic [1:0] PFM_FN2 = 2'h2;
   localparam logic [1:0] PFM_FN3 = 2'h3;
   // Pin indices
   localparam int PFM_NPIN = 15;
   localparam int PFM_P0B0 = 0;
   localparam int PFM_P0B1 = 1;
   localparam int PFM_P1B0 = 2;
   localparam int PFM_P1B1 = 3;
   localparam int PFM_P1B2 = 4;
   localparam int PFM_P1B3 = 5;
   localparam int PFM_P1B4 = 6;
   localparam int PFM_P1B5 = 7;
   localparam int PFM_P1B6 = 8;
   localparam int PFM_P2B5 = 9;
   localparam int PFM_P2B6 = 10;
   localparam int PFM_P2B7 = 11;
   localparam int PFM_P3B0 = 12;
   localparam int PFM_P3B1 = 13;
   localparam int PFM_P3B2 = 14;
   // Legal codes per pin, four bits a pin, pin 0 in the low nibble
   localparam logic [59:0] PFM_VALID = 60'hF_F_3_5_5_5_3_3_3_F_3_3_3_3_3;
   // Input level a function sees while not selected (active-low ones idle high)
   localparam logic [59:0] PFM_IDLE = 60'h0_E_0_0_0_4_0_0_0_6_0_0_0_0_0;
   // Peripheral-bound inputs at reset: only the active-low ones sit high
   localparam logic [12:0] PFM_PERIPH_RESET = 13'h1C30;
endpackage

// ==== verilog/pfm_sel_reg.sv ====
// One 8-bit function select register with reserved bits forced to zero
`timescale 1ns/100ps
module pfm_sel_reg #(
   parameter logic [7:0] WMASK = 8'hFF
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Write port
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   // Stored value
   output logic [7:0] q_o
);
   logic [7:0] q_q;
   logic [7:0] q_d;

   // Reserved positions never store a one, so they always read back zero
   assign q_d = wr_i ? (wdata_i & WMASK) : q_q;
   assign q_o = q_q;

   // Storage, synchronous reset
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         q_q <= pfm_pkg::PFM_SEL_RESET;
      end else begin
         q_q <= q_d;
      end
   end
endmodule

// ==== verilog/pfm_pin_cell.sv ====
// Four-way function multiplexer for one pin, pad side registered
`timescale 1ns/100ps
module pfm_pin_cell #(
   parameter logic [3:0] VALID = 4'h3,
   parameter logic [3:0] IDLE = 4'h0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Select field
   input wire logic [1:0] sel_i,
   // Function side
   input wire logic [3:0] fn_out_i,
   input wire logic [3:0] fn_oe_n_i,
   output logic [3:0] fn_in_o,
   output logic [3:0] fn_act_o,
   // Pad side
   input wire logic pad_in_i,
   output logic pad_o,
   output logic pad_oe_n_o
);
   logic [1:0] eff_sel;
   logic pad_q;
   logic pad_d;
   logic pad_oe_n_q;
   logic pad_oe_n_d;

   // A reserved code falls back to function 0
   assign eff_sel = VALID[sel_i] ? sel_i : pfm_pkg::PFM_FN0;
   assign fn_act_o = 4'h1 << eff_sel;
   // Unselected functions see their idle level, not the pad
   assign fn_in_o = (fn_act_o & {4{pad_in_i}}) | (~fn_act_o & IDLE);
   assign pad_d = fn_out_i[eff_sel];
   assign pad_oe_n_d = fn_oe_n_i[eff_sel];
   assign pad_o = pad_q;
   assign pad_oe_n_o = pad_oe_n_q;

   // Pad drive registered; pad released during reset
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         pad_q <= 1'b0;
         pad_oe_n_q <= 1'b1;
      end else begin
         pad_q <= pad_d;
         pad_oe_n_q <= pad_oe_n_d;
      end
   end
endmodule

// ==== verilog/pfm_port_function_select_mux.sv ====
// Port function select registers and pin multiplexer, top level
//
// Contract
// [R1] port0_bit1 code 01 selects analog_in_1
// [R2] port0 D[1:0] code 01 selects analog_in_0
// [R3] port1 low register at 0x4422, resets zero
// [R4] port1_bit3: 11 sdi0, 10 ssel1, 01 ssel0
// [R5] port1_bit2 code 01 selects serial0_clock
// [R6] port1_bit1 code 01 selects serial0_data_out
// [R7] port1_bit0 code 01 selects serial0_data_in
// [R8] port1 high at 0x4423, D7-6 read zero
// [R9] port1_bit6 code 01 selects serial1_clock
// [R10] port1_bit5 code 01 selects serial1_data_out
// [R11] port1_bit4 code 01 selects serial1_data_in
// [R12] port2 high at 0x4425, D1-0 read zero
// [R13] port2_bit7 code 10 selects twowire clock
// [R14] port2_bit6 code 10 selects twowire data
// [R15] port2_bit5 code 10 selects twowire reset
// [R16] port3 low at 0x4426, D7-6 read zero
// [R17] port3_bit2: clock unit, watchdog nmi, watchdog clock
// [R18] port3_bit1: adc trigger, timer0 input, twowire reset
// [R19] port3_bit0 code 01 selects timer0_out
// [R20] Software writes zero into reserved bits
// [R21] Reserved code acts as 00, stays readable
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
module pfm_port_function_select_mux #(
   parameter int NPIN = pfm_pkg::PFM_NPIN
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Register port
   input wire logic [15:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Pads
   input wire logic [NPIN-1:0] pad_in_i,
   output logic [NPIN-1:0] pad_o,
   output logic [NPIN-1:0] pad_oe_n_o,
   // General port function
   input wire logic [NPIN-1:0] gpio_out_i,
   input wire logic [NPIN-1:0] gpio_oe_n_i,
   output logic [NPIN-1:0] gpio_in_o,
   // Analog inputs
   output logic analog_in_0_en_o,
   output logic analog_in_1_en_o,
   // Serial channel 0
   output logic serial0_data_in_o,
   input wire logic serial0_data_out_i,
   input wire logic serial0_clock_out_i,
   input wire logic serial0_clock_oe_n_i,
   output logic serial0_clock_in_o,
   output logic serial0_select_n_o,
   // Serial channel 1
   output logic serial1_select_n_o,
   output logic serial1_data_in_o,
   input wire logic serial1_data_out_i,
   input wire logic serial1_clock_out_i,
   input wire logic serial1_clock_oe_n_i,
   output logic serial1_clock_in_o,
   // Two-wire slave, open drain
   input wire logic slave_twowire_clock_low_i,
   input wire logic slave_twowire_data_low_i,
   output logic slave_twowire_clock_in_o,
   output logic slave_twowire_data_in_o,
   output logic slave_twowire_reset_n_o,
   // Timer, trigger, watchdog and clock unit
   input wire logic timer0_out_i,
   output logic timer0_ext_in_n_o,
   output logic adc_trigger_n_o,
   input wire logic watchdog_clock_out_i,
   input wire logic watchdog_nmi_out_n_i,
   input wire logic clock_unit_clock_out_i
);
   // Extract a two-bit field
   function automatic logic [1:0] field(input logic [7:0] r, input int lsb);
      field = r[lsb +: 2];
   endfunction

   // Register contents
   logic [7:0] port0_sel;
   logic [7:0] port1_low_sel;
   logic [7:0] port1_high_sel;
   logic [7:0] port2_high_sel;
   logic [7:0] port3_low_sel;
   // Address decode
   logic hit_p0;
   logic hit_p1l;
   logic hit_p1h;
   logic hit_p2h;
   logic hit_p3l;
   // Read path
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   // Per pin select and function vectors
   logic [1:0] pin_sel [NPIN];
   logic [3:0] fo [NPIN];
   logic [3:0] foe [NPIN];
   logic [3:0] fin [NPIN];
   logic [3:0] fact [NPIN];
   // Peripheral-bound registers
   logic [NPIN-1:0] gpio_in_q;
   logic [NPIN-1:0] gpio_in_d;
   logic [12:0] periph_q;
   logic [12:0] periph_d;

   // Register decode
   assign hit_p0 = addr_i == pfm_pkg::PFM_ADDR_PORT0_SEL;
   assign hit_p1l = addr_i == pfm_pkg::PFM_ADDR_PORT1_LOW_SEL; // [R3]
   assign hit_p1h = addr_i == pfm_pkg::PFM_ADDR_PORT1_HIGH_SEL; // [R8]
   assign hit_p2h = addr_i == pfm_pkg::PFM_ADDR_PORT2_HIGH_SEL; // [R12]
   assign hit_p3l = addr_i == pfm_pkg::PFM_ADDR_PORT3_LOW_SEL; // [R16]

   // Select registers; masks clear reserved bits even if software breaks [R20]
   pfm_sel_reg #(.WMASK(pfm_pkg::PFM_MASK_PORT0)) u_reg_p0 (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .wr_i(wr_i & hit_p0), .wdata_i(wdata_i),
      .q_o(port0_sel)
   );
   pfm_sel_reg #(.WMASK(pfm_pkg::PFM_MASK_PORT1_LOW)) u_reg_p1l ( // [R3]
      .clk_i(clk_i), .rst_b_i(rst_b_i), .wr_i(wr_i & hit_p1l), .wdata_i(wdata_i),
      .q_o(port1_low_sel)
   );
   pfm_sel_reg #(.WMASK(pfm_pkg::PFM_MASK_PORT1_HIGH)) u_reg_p1h ( // [R8]
      .clk_i(clk_i), .rst_b_i(rst_b_i), .wr_i(wr_i & hit_p1h), .wdata_i(wdata_i),
      .q_o(port1_high_sel)
   );
   pfm_sel_reg #(.WMASK(pfm_pkg::PFM_MASK_PORT2_HIGH)) u_reg_p2h ( // [R12]
      .clk_i(clk_i), .rst_b_i(rst_b_i), .wr_i(wr_i & hit_p2h), .wdata_i(wdata_i),
      .q_o(port2_high_sel)
   );
   pfm_sel_reg #(.WMASK(pfm_pkg::PFM_MASK_PORT3_LOW)) u_reg_p3l ( // [R16]
      .clk_i(clk_i), .rst_b_i(rst_b_i), .wr_i(wr_i & hit_p3l), .wdata_i(wdata_i),
      .q_o(port3_low_sel)
   );

   // Read mux; the stored code reads back even when it is reserved [R21]
   assign rdata_d = !rd_i ? 8'h00 :
                    hit_p0 ? port0_sel :
                    hit_p1l ? port1_low_sel :
                    hit_p1h ? port1_high_sel :
                    hit_p2h ? port2_high_sel :
                    hit_p3l ? port3_low_sel : 8'h00;
   assign rdata_o = rdata_q;

   // Field to pin mapping; port0 bits 4 to 7 are stored only
   assign pin_sel[pfm_pkg::PFM_P0B0] = field(port0_sel, pfm_pkg::PFM_FLD0_LSB); // [R2]
   assign pin_sel[pfm_pkg::PFM_P0B1] = field(port0_sel, pfm_pkg::PFM_FLD1_LSB); // [R1]
   assign pin_sel[pfm_pkg::PFM_P1B0] = field(port1_low_sel, pfm_pkg::PFM_FLD0_LSB); // [R7]
   assign pin_sel[pfm_pkg::PFM_P1B1] = field(port1_low_sel, pfm_pkg::PFM_FLD1_LSB); // [R6]
   assign pin_sel[pfm_pkg::PFM_P1B2] = field(port1_low_sel, pfm_pkg::PFM_FLD2_LSB); // [R5]
   assign pin_sel[pfm_pkg::PFM_P1B3] = field(port1_low_sel, pfm_pkg::PFM_FLD3_LSB); // [R4]
   assign pin_sel[pfm_pkg::PFM_P1B4] = field(port1_high_sel, pfm_pkg::PFM_FLD0_LSB); // [R11]
   assign pin_sel[pfm_pkg::PFM_P1B5] = field(port1_high_sel, pfm_pkg::PFM_FLD1_LSB); // [R10]
   assign pin_sel[pfm_pkg::PFM_P1B6] = field(port1_high_sel, pfm_pkg::PFM_FLD2_LSB); // [R9]
   assign pin_sel[pfm_pkg::PFM_P2B5] = field(port2_high_sel, pfm_pkg::PFM_FLD1_LSB); // [R15]
   assign pin_sel[pfm_pkg::PFM_P2B6] = field(port2_high_sel, pfm_pkg::PFM_FLD2_LSB); // [R14]
   assign pin_sel[pfm_pkg::PFM_P2B7] = field(port2_high_sel, pfm_pkg::PFM_FLD3_LSB); // [R13]
   assign pin_sel[pfm_pkg::PFM_P3B0] = field(port3_low_sel, pfm_pkg::PFM_FLD0_LSB); // [R19]
   assign pin_sel[pfm_pkg::PFM_P3B1] = field(port3_low_sel, pfm_pkg::PFM_FLD1_LSB); // [R18]
   assign pin_sel[pfm_pkg::PFM_P3B2] = field(port3_low_sel, pfm_pkg::PFM_FLD2_LSB); // [R17]

   // Outbound function sources per pin; unused slots float the pad
   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         fo[i] = {3'h0, gpio_out_i[i]};
         foe[i] = {3'h7, gpio_oe_n_i[i]};
      end
      // Serial 0 data out and bidirectional clock
      fo[pfm_pkg::PFM_P1B1][1] = serial0_data_out_i; // [R6]
      foe[pfm_pkg::PFM_P1B1][1] = 1'b0;
      fo[pfm_pkg::PFM_P1B2][1] = serial0_clock_out_i; // [R5]
      foe[pfm_pkg::PFM_P1B2][1] = serial0_clock_oe_n_i;
      // Serial 1 data out and bidirectional clock
      fo[pfm_pkg::PFM_P1B5][1] = serial1_data_out_i; // [R10]
      foe[pfm_pkg::PFM_P1B5][1] = 1'b0;
      fo[pfm_pkg::PFM_P1B6][1] = serial1_clock_out_i; // [R9]
      foe[pfm_pkg::PFM_P1B6][1] = serial1_clock_oe_n_i;
      // Two-wire lines only ever pull low
      foe[pfm_pkg::PFM_P2B6][2] = ~slave_twowire_data_low_i; // [R14]
      foe[pfm_pkg::PFM_P2B7][2] = ~slave_twowire_clock_low_i; // [R13]
      // Timer output
      fo[pfm_pkg::PFM_P3B0][1] = timer0_out_i; // [R19]
      foe[pfm_pkg::PFM_P3B0][1] = 1'b0;
      // Watchdog clock, watchdog nmi, clock unit clock
      fo[pfm_pkg::PFM_P3B2][1] = watchdog_clock_out_i; // [R17]
      foe[pfm_pkg::PFM_P3B2][1] = 1'b0;
      fo[pfm_pkg::PFM_P3B2][2] = watchdog_nmi_out_n_i;
      foe[pfm_pkg::PFM_P3B2][2] = 1'b0;
      fo[pfm_pkg::PFM_P3B2][3] = clock_unit_clock_out_i;
      foe[pfm_pkg::PFM_P3B2][3] = 1'b0;
   end

   // One multiplexer cell per pin
   for (genvar g = 0; g < NPIN; g++) begin : g_pin
      pfm_pin_cell #(
         .VALID(pfm_pkg::PFM_VALID[4*g +: 4]),
         .IDLE(pfm_pkg::PFM_IDLE[4*g +: 4])
      ) u_cell (
         .clk_i(clk_i),
         .rst_b_i(rst_b_i),
         .sel_i(pin_sel[g]), // [R21]
         .fn_out_i(fo[g]),
         .fn_oe_n_i(foe[g]),
         .fn_in_o(fin[g]),
         .fn_act_o(fact[g]),
         .pad_in_i(pad_in_i[g]),
         .pad_o(pad_o[g]),
         .pad_oe_n_o(pad_oe_n_o[g])
      );
      assign gpio_in_d[g] = fin[g][0];
   end

   // Inbound routing; shared inputs combine the pins that may carry them
   assign periph_d[0] = fact[pfm_pkg::PFM_P0B0][1]; // [R2]
   assign periph_d[1] = fact[pfm_pkg::PFM_P0B1][1]; // [R1]
   assign periph_d[2] = fin[pfm_pkg::PFM_P1B0][1] | fin[pfm_pkg::PFM_P1B3][3]; // [R7] [R4]
   assign periph_d[3] = fin[pfm_pkg::PFM_P1B2][1]; // [R5]
   assign periph_d[4] = fin[pfm_pkg::PFM_P1B3][1]; // [R4]
   assign periph_d[5] = fin[pfm_pkg::PFM_P1B3][2]; // [R4]
   assign periph_d[6] = fin[pfm_pkg::PFM_P1B4][1]; // [R11]
   assign periph_d[7] = fin[pfm_pkg::PFM_P1B6][1]; // [R9]
   assign periph_d[8] = fin[pfm_pkg::PFM_P2B7][2]; // [R13]
   assign periph_d[9] = fin[pfm_pkg::PFM_P2B6][2]; // [R14]
   // Reset asserts when either carrying pin is low
   assign periph_d[10] = fin[pfm_pkg::PFM_P2B5][2] & fin[pfm_pkg::PFM_P3B1][1]; // [R15] [R18]
   assign periph_d[11] = fin[pfm_pkg::PFM_P3B1][2]; // [R18]
   assign periph_d[12] = fin[pfm_pkg::PFM_P3B1][3]; // [R18]

   assign gpio_in_o = gpio_in_q;
   assign analog_in_0_en_o = periph_q[0];
   assign analog_in_1_en_o = periph_q[1];
   assign serial0_data_in_o = periph_q[2];
   assign serial0_clock_in_o = periph_q[3];
   assign serial0_select_n_o = periph_q[4];
   assign serial1_select_n_o = periph_q[5];
   assign serial1_data_in_o = periph_q[6];
   assign serial1_clock_in_o = periph_q[7];
   assign slave_twowire_clock_in_o = periph_q[8];
   assign slave_twowire_data_in_o = periph_q[9];
   assign slave_twowire_reset_n_o = periph_q[10];
   assign timer0_ext_in_n_o = periph_q[11];
   assign adc_trigger_n_o = periph_q[12];

   // Output flops; reset shows idle levels so active-low inputs stay quiet
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         rdata_q <= 8'h00;
         gpio_in_q <= '0;
         periph_q <= pfm_pkg::PFM_PERIPH_RESET;
      end else begin
         rdata_q <= rdata_d;
         gpio_in_q <= gpio_in_d;
         periph_q <= periph_d;
      end
   end

   // Checks
   sequence s_write_p1h;
      wr_i && hit_p1h;
   endsequence
   sequence s_read_p1h;
      rd_i && hit_p1h;
   endsequence
   sequence s_write_p3l;
      wr_i && hit_p3l;
   endsequence
   sequence s_read_p3l;
      rd_i && hit_p3l && !wr_i;
   endsequence

   // Write, an idle cycle, then read back with the reserved pair clear
   a_p1h_resv_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R8]
      s_write_p1h ##1 !wr_i ##1 s_read_p1h
      |=> rdata_o[7:6] == 2'h0 && rdata_o == ($past(wdata_i, 3) & pfm_pkg::PFM_MASK_PORT1_HIGH))
      else $error("port1 high reserved bits read nonzero");
   // Reserved low pair
   a_p2h_resv_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R12]
      rd_i && hit_p2h |=> rdata_o[1:0] == 2'h0)
      else $error("port2 high reserved bits read nonzero");
   // Readback after one idle cycle
   a_p3l_readback: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R16]
      s_write_p3l ##1 !wr_i ##1 s_read_p3l
      |=> rdata_o == ($past(wdata_i, 3) & pfm_pkg::PFM_MASK_PORT3_LOW))
      else $error("port3 low read back wrong");
   // Any reset cycle clears the register and the read port
   a_p1l_reset: assert property (@(posedge clk_i) // [R3]
      !rst_b_i |=> port1_low_sel == pfm_pkg::PFM_SEL_RESET && rdata_o == 8'h00)
      else $error("port1 low not zero after reset");
   // Timer output
   a_timer_route: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R19]
      pin_sel[pfm_pkg::PFM_P3B0] == pfm_pkg::PFM_FN1
      |=> pad_o[pfm_pkg::PFM_P3B0] == $past(timer0_out_i) && !pad_oe_n_o[pfm_pkg::PFM_P3B0])
      else $error("timer0 output not on its pin");
   // Serial 0 data out
   a_sdo0_route: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R6]
      pin_sel[pfm_pkg::PFM_P1B1] == pfm_pkg::PFM_FN1
      |=> pad_o[pfm_pkg::PFM_P1B1] == $past(serial0_data_out_i))
      else $error("serial0 data out not on its pin");
   // Watchdog nmi
   a_nmi_route: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R17]
      pin_sel[pfm_pkg::PFM_P3B2] == pfm_pkg::PFM_FN2
      |=> pad_o[pfm_pkg::PFM_P3B2] == $past(watchdog_nmi_out_n_i))
      else $error("watchdog nmi not on its pin");
   // Reserved code falls back to the port
   a_resv_as_gpio: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R21]
      pin_sel[pfm_pkg::PFM_P1B2] == pfm_pkg::PFM_FN3
      |=> pad_oe_n_o[pfm_pkg::PFM_P1B2] == $past(gpio_oe_n_i[pfm_pkg::PFM_P1B2]))
      else $error("reserved code did not act as port");
   // Serial 0 data in from its second pin
   a_sdi0_alt: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R4]
      pin_sel[pfm_pkg::PFM_P1B3] == pfm_pkg::PFM_FN3 && pin_sel[pfm_pkg::PFM_P1B0] == 2'h0
      |=> serial0_data_in_o == $past(pad_in_i[pfm_pkg::PFM_P1B3]))
      else $error("serial0 data in not taken from alternate pin");
   // Two-wire reset from port2
   a_twr_route: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R15]
      pin_sel[pfm_pkg::PFM_P2B5] == pfm_pkg::PFM_FN2 && !pad_in_i[pfm_pkg::PFM_P2B5]
      |=> !slave_twowire_reset_n_o)
      else $error("twowire reset not asserted from pin");
   // Analog pins are released
   a_analog_in_0_en: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R2]
      pin_sel[pfm_pkg::PFM_P0B0] == pfm_pkg::PFM_FN1
      |=> analog_in_0_en_o && pad_oe_n_o[pfm_pkg::PFM_P0B0])
      else $error("analog_in_0 not released");
   a_analog_in_1_en: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R1]
      pin_sel[pfm_pkg::PFM_P0B1] == pfm_pkg::PFM_FN1
      |=> analog_in_1_en_o && pad_oe_n_o[pfm_pkg::PFM_P0B1])
      else $error("analog_in_1 not released");
   // Serial clocks carry both drive and enable
   a_s0clk_route: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R5]
      pin_sel[pfm_pkg::PFM_P1B2] == pfm_pkg::PFM_FN1
      |=> pad_o[pfm_pkg::PFM_P1B2] == $past(serial0_clock_out_i)
      && pad_oe_n_o[pfm_pkg::PFM_P1B2] == $past(serial0_clock_oe_n_i))
      else $error("serial0 clock not on its pin");
   a_s1clk_route: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R9]
      pin_sel[pfm_pkg::PFM_P1B6] == pfm_pkg::PFM_FN1
      |=> pad_o[pfm_pkg::PFM_P1B6] == $past(serial1_clock_out_i)
      && pad_oe_n_o[pfm_pkg::PFM_P1B6] == $past(serial1_clock_oe_n_i))
      else $error("serial1 clock not on its pin");
   // Serial 1 data out and in
   a_sdo1_route: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R10]
      pin_sel[pfm_pkg::PFM_P1B5] == pfm_pkg::PFM_FN1
      |=> pad_o[pfm_pkg::PFM_P1B5] == $past(serial1_data_out_i) && !pad_oe_n_o[pfm_pkg::PFM_P1B5])
      else $error("serial1 data out not on its pin");
   a_sdi1_route: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R11]
      pin_sel[pfm_pkg::PFM_P1B4] == pfm_pkg::PFM_FN1
      |=> serial1_data_in_o == $past(pad_in_i[pfm_pkg::PFM_P1B4]))
      else $error("serial1 data in not taken from pin");
   // Two-wire clock only ever pulls low
   a_twclk_pull: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R13]
      pin_sel[pfm_pkg::PFM_P2B7] == pfm_pkg::PFM_FN2
      |=> !pad_o[pfm_pkg::PFM_P2B7]
      && pad_oe_n_o[pfm_pkg::PFM_P2B7] == !$past(slave_twowire_clock_low_i))
      else $error("twowire clock pull wrong");
endmodule

// ==== verif/pfm_far_side.sv ====
// Far-side pad model: external parts that share each pad with the device
`timescale 1ns/100ps
module pfm_far_side #(
   parameter int NPIN = 15
) (
   // Device drive toward the pads
   input wire logic [NPIN-1:0] pad_o_i,
   input wire logic [NPIN-1:0] pad_oe_n_i,
   // External drivers, heard only where the device lets go
   input wire logic [NPIN-1:0] ext_i,
   // Resolved pad level fed back to the device
   output logic [NPIN-1:0] pad_in_o
);
   // Device wins where it drives; no keeper, so a released pad shows the outside level
   assign pad_in_o = (pad_o_i & ~pad_oe_n_i) | (ext_i & pad_oe_n_i);
endmodule

// ==== verif/pfm_port_function_select_mux_bench.sv ====
// Self-checking bench for the port function select multiplexer
`timescale 1ns/100ps
module pfm_port_function_select_mux_bench;
   localparam int NP = pfm_pkg::PFM_NPIN;
   // Clock, reset and register port
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   // Pads and general port
   logic [NP-1:0] ext = '0;
   logic [NP-1:0] pad_o, pad_oe_n, pad_in, gpio_in;
   logic [NP-1:0] gpio_out = '0;
   logic [NP-1:0] gpio_oe_n = '1;
   // Peripheral drive: 0 s0dout,1 s0clk,2 s0oe_n,3 s1dout,4 s1clk,5 s1oe_n,
   // 6 twclk low,7 twdat low,8 timer,9 wdclk,10 wdnmi_n,11 cuclk
   logic [11:0] pv = 12'h424;
   // Peripheral inputs: 0 an0,1 an1,2 s0din,3 s0clkin,4 s0sel_n,5 s1sel_n,
   // 6 s1din,7 s1clkin,8 twclk,9 twdat,10 twrst_n,11 tmrext_n,12 adc_trigger_n_n
   logic [12:0] po;
   int mismatches = 0;
   int total_checks = 0;

   // Free-running clock, 25 ns period
   always #12.5 clk_i = ~clk_i;

   pfm_port_function_select_mux DUT (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .pad_in_i(pad_in), .pad_o(pad_o), .pad_oe_n_o(pad_oe_n),
      .gpio_out_i(gpio_out), .gpio_oe_n_i(gpio_oe_n), .gpio_in_o(gpio_in),
      .analog_in_0_en_o(po[0]), .analog_in_1_en_o(po[1]),
      .serial0_data_in_o(po[2]), .serial0_data_out_i(pv[0]),
      .serial0_clock_out_i(pv[1]), .serial0_clock_oe_n_i(pv[2]),
      .serial0_clock_in_o(po[3]), .serial0_select_n_o(po[4]),
      .serial1_select_n_o(po[5]), .serial1_data_in_o(po[6]),
      .serial1_data_out_i(pv[3]), .serial1_clock_out_i(pv[4]),
      .serial1_clock_oe_n_i(pv[5]), .serial1_clock_in_o(po[7]),
      .slave_twowire_clock_low_i(pv[6]), .slave_twowire_data_low_i(pv[7]),
      .slave_twowire_clock_in_o(po[8]), .slave_twowire_data_in_o(po[9]),
      .slave_twowire_reset_n_o(po[10]), .timer0_out_i(pv[8]),
      .timer0_ext_in_n_o(po[11]), .adc_trigger_n_o(po[12]),
      .watchdog_clock_out_i(pv[9]), .watchdog_nmi_out_n_i(pv[10]),
      .clock_unit_clock_out_i(pv[11])
   );

   pfm_far_side #(.NPIN(NP)) far (
      .pad_o_i(pad_o), .pad_oe_n_i(pad_oe_n), .ext_i(ext), .pad_in_o(pad_in)
   );

   // Single comparison point; case inequality so unknowns never match
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One-cycle write strobe
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask

   // One-cycle read strobe; data stands only in the following cycle
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_i);
      rd <= 1'b0;
      #1;
      chk("rdata", {8'h00, rdata}, {8'h00, exp});
   endtask

   // Pin path is registered: allow the select and the pad stage to land
   task automatic settle();
      repeat (2) @(posedge clk_i);
      #1;
   endtask

   // Reset state of registers and pins
   task automatic t_reset();
      rd_chk(16'h4420, 8'h00);
      rd_chk(16'h4422, 8'h00);
      rd_chk(16'h4423, 8'h00);
      rd_chk(16'h4425, 8'h00);
      rd_chk(16'h4426, 8'h00);
      ext <= 15'h2AD5;
      settle();
      chk("oe_n", {1'b0, pad_oe_n}, 16'h7FFF);
      chk("gpio_in", {1'b0, gpio_in}, 16'h2AD5);
      chk("periph", {3'b000, po}, 16'h1C30);
   endtask

   // Reserved bits read zero, reserved codes read back but act as default
   task automatic t_regs();
      logic [15:0] ad [5] = '{16'h4420, 16'h4422, 16'h4423, 16'h4425, 16'h4426};
      logic [7:0] ex [5] = '{8'hFF, 8'hFF, 8'h3F, 8'hFC, 8'h3F};
      pv <= 12'hB1B;
      gpio_oe_n <= '0;
      for (int i = 0; i < 5; i++) begin
         wr_reg(ad[i], ex[i]);
         rd_chk(ad[i], ex[i]);
      end
      wr_reg(16'h4421, 8'hFF);
      rd_chk(16'h4421, 8'h00);
      rd_chk(16'h4424, 8'h00);
      settle();
      chk("rsv oe_n", {1'b0, pad_oe_n}, 16'h2020);
      chk("rsv an", {14'h0, po[1:0]}, 16'h0000);
      gpio_oe_n <= '1;
   endtask

   // Peripheral outputs reach their pads
   task automatic t_outputs();
      logic [15:0] pd [4] = '{16'h0000, 16'h0001, 16'h0000, 16'h0001};
      logic [15:0] oe [4] = '{16'h0001, 16'h0000, 16'h0000, 16'h0000};
      wr_reg(16'h4420, 8'h00);
      wr_reg(16'h4422, 8'h14);
      wr_reg(16'h4423, 8'h14);
      wr_reg(16'h4425, 8'h00);
      wr_reg(16'h4426, 8'h01);
      settle();
      chk("out oe_n", {1'b0, pad_oe_n}, 16'h6E67);
      chk("out pad", {1'b0, pad_o & 15'h1198}, 16'h1198);
      for (int c = 0; c < 4; c++) begin
         wr_reg(16'h4426, {2'b00, c[1:0], 4'h0});
         settle();
         chk("p3b2 pad", {15'h0, pad_o[14]}, pd[c]);
         chk("p3b2 oe_n", {15'h0, pad_oe_n[14]}, oe[c]);
      end
      pv <= 12'h464;
      wr_reg(16'h4425, 8'hA8);
      settle();
      chk("tw oe_n", {14'h0, pad_oe_n[11:10]}, 16'h0001);
      chk("tw pad", {15'h0, pad_o[11]}, 16'h0000);
   endtask

   // Pad levels reach the selected peripheral inputs
   task automatic t_inputs();
      logic [15:0] e1 [4] = '{16'h0, 16'h8, 16'h4, 16'hC};
      logic [15:0] e2 [4] = '{16'h0, 16'h6, 16'h5, 16'h3};
      pv <= 12'h424;
      gpio_oe_n <= '0;
      ext <= '0;
      wr_reg(16'h4420, 8'h05);
      wr_reg(16'h4422, 8'h11);
      wr_reg(16'h4423, 8'h11);
      wr_reg(16'h4426, 8'h00);
      settle();
      chk("in oe_n", {1'b0, pad_oe_n}, 16'h0F57);
      chk("in lo", {3'b000, po}, 16'h1833);
      ext <= '1;
      settle();
      chk("in hi", {3'b000, po}, 16'h1FFF);
      ext <= '0;
      gpio_oe_n <= '1;
      wr_reg(16'h4425, 8'h00);
      for (int c = 1; c < 4; c++) begin
         wr_reg(16'h4422, {c[1:0], 6'h00});
         wr_reg(16'h4426, {4'h0, c[1:0], 2'b00});
         settle();
         chk("p1b3", {12'h0, po[5:2]}, e1[c]);
         chk("p3b1", {13'h0, po[12:10]}, e2[c]);
      end
      ext <= 15'h0020;
      settle();
      chk("p1b3 sdi", {12'h0, po[5:2]}, 16'h000D);
   endtask

   // Counts, verdict and end of run
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (20) @(posedge clk_i);
      rst_b_i <= 1'b1;
      t_reset();
      t_regs();
      t_outputs();
      t_inputs();
      final_report();
   end

   // Watchdog: the sequence needs about 130 cycles
   initial begin
      repeat (5000) @(posedge clk_i);
      mismatches++;
      final_report();
   end
endmodule
